//--- rtl/pmac_multiplier.v
`timescale 1ns/100ps
`include "pmac_regs.vh"

// registered 16x16 multiplier, one cycle from in_valid to out_valid
module pmac_multiplier #(
    parameter WIDTH = 16
) (
    input wire clk,
    input wire srst,
    input wire in_valid,
    input wire is_signed,
    input wire [WIDTH-1:0] op_a,
    input wire [WIDTH-1:0] op_b,
    output wire out_valid,
    output wire [2*WIDTH-1:0] product
);

    wire signed [WIDTH:0] ext_a;
    wire signed [WIDTH:0] ext_b;
    wire signed [2*WIDTH+1:0] full_product;
    reg valid_reg;
    reg [2*WIDTH-1:0] product_reg;

    // one signed 17x17 array serves both modes; the extra bit is the sign or zero
    // RULE_08: two's complement product
    assign ext_a = {is_signed & op_a[WIDTH-1], op_a};
    assign ext_b = {is_signed & op_b[WIDTH-1], op_b};
    assign full_product = ext_a * ext_b;

    // valid flag is reset, the product word need not be
    always @(posedge clk) begin
        if (srst) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= in_valid;
        end
    end

    // low 32 bits hold the exact product in either mode
    always @(posedge clk) begin
        product_reg <= full_product[2*WIDTH-1:0];
    end

    assign out_valid = valid_reg;
    assign product = product_reg;

endmodule // pmac_multiplier

//--- rtl/pmac_operand_reg.v
`timescale 1ns/100ps
`include "pmac_regs.vh"

// one operand register; contents survive reset on purpose
module pmac_operand_reg #(
    parameter WIDTH = 16
) (
    input wire clk,
    input wire wen,
    input wire byte_wr,
    input wire [WIDTH-1:0] wdata,
    output wire [WIDTH-1:0] q
);

    reg [WIDTH-1:0] value_reg;
    reg [WIDTH-1:0] value_next;

    // byte writes zero the upper byte, so signed bytes need explicit extension
    always @* begin
        value_next = value_reg;
        if (wen) begin
            // RULE_13: byte or word
            if (byte_wr) begin
                // RULE_17: clear upper byte
                value_next = {{(WIDTH-8){1'b0}}, wdata[`PMAC_BYTE_MSB:`PMAC_BYTE_LSB]};
            end else begin
                value_next = wdata;
            end
        end
    end

    // no reset: operands are left unchanged by a system reset
    always @(posedge clk) begin
        value_reg <= value_next;
    end

    assign q = value_reg;

endmodule // pmac_operand_reg

//--- rtl/pmac_regs.vh
`ifndef PMAC_REGS_VH
`define PMAC_REGS_VH

// register byte addresses on the peripheral bus
`define PMAC_ADDR_OPA_UPROD 16'h0130
`define PMAC_ADDR_OPA_SPROD 16'h0132
`define PMAC_ADDR_OPA_UACC 16'h0134
`define PMAC_ADDR_OPA_SACC 16'h0136
`define PMAC_ADDR_OPB 16'h0138
`define PMAC_ADDR_RES_LO 16'h013a
`define PMAC_ADDR_RES_HI 16'h013c
`define PMAC_ADDR_RES_EXT 16'h013e

// register indices after decode
`define PMAC_IDX_NONE 4'h0
`define PMAC_IDX_OPA 4'h1
`define PMAC_IDX_OPB 4'h2
`define PMAC_IDX_RES_LO 4'h3
`define PMAC_IDX_RES_HI 4'h4
`define PMAC_IDX_RES_EXT 4'h5

// operation modes, selected by the first operand address
`define PMAC_MODE_UPROD 2'h0
`define PMAC_MODE_SPROD 2'h1
`define PMAC_MODE_UACC 2'h2
`define PMAC_MODE_SACC 2'h3

// field layout and fixed values
`define PMAC_BYTE_LSB 0
`define PMAC_BYTE_MSB 7
`define PMAC_UPPER_BYTE_CLR 8'h00
`define PMAC_EXT_ZERO 16'h0000
`define PMAC_EXT_ONES 16'hffff
`define PMAC_EXT_CARRY 16'h0001
`define PMAC_RDATA_UNMAPPED 16'h0000

// reset values of control state
`define PMAC_MODE_RESET 2'h0
`define PMAC_RDATA_RESET 16'h0000

// cycles from second operand write to results
`define PMAC_RESULT_LATENCY 3

`endif

//--- rtl/pmac_top.v
`timescale 1ns/100ps
`include "pmac_regs.vh"

// Function
// RULE_01: four first-operand addresses select the operation
// RULE_02: first-operand write stores operand, latches mode only
// RULE_03: second-operand write starts the latched operation
// RULE_04: all results valid three cycles later
// RULE_05: first operand and mode persist for reuse
// RULE_06: low result gets product bits 15..0
// RULE_07: unsigned product: upper half, extension zero
// RULE_08: signed product in two's complement, sign high
// RULE_09: signed modes: extension all ones when negative
// RULE_10: unsigned accumulate: extension holds carry out
// RULE_11: signed accumulate wraps as 32-bit value
// RULE_12: no overflow flag; extension shows true sign
// RULE_13: operands accept byte and word writes
// RULE_14: CPU waits one instruction for indirect reads
// RULE_15: CPU keeps interrupts off between operand writes
// RULE_16: accumulate adds product to held result pair
// RULE_17: byte write clears operand upper byte
module pmac_top #(
    parameter WIDTH = 16
) (
    input wire clk,
    input wire srst,
    input wire [15:0] per_addr,
    input wire [WIDTH-1:0] per_wdata,
    input wire per_wen,
    input wire per_byte,
    input wire per_ren,
    output wire [WIDTH-1:0] per_rdata,
    output wire busy,
    output wire result_valid
);

    // decode of a bus address into a register index
    // only the even word addresses decode; an odd address answers as unmapped
    function [3:0] reg_index;
        input [15:0] addr;
        begin
            case (addr)
                `PMAC_ADDR_OPA_UPROD: reg_index = `PMAC_IDX_OPA;
                `PMAC_ADDR_OPA_SPROD: reg_index = `PMAC_IDX_OPA;
                `PMAC_ADDR_OPA_UACC: reg_index = `PMAC_IDX_OPA;
                `PMAC_ADDR_OPA_SACC: reg_index = `PMAC_IDX_OPA;
                `PMAC_ADDR_OPB: reg_index = `PMAC_IDX_OPB;
                `PMAC_ADDR_RES_LO: reg_index = `PMAC_IDX_RES_LO;
                `PMAC_ADDR_RES_HI: reg_index = `PMAC_IDX_RES_HI;
                `PMAC_ADDR_RES_EXT: reg_index = `PMAC_IDX_RES_EXT;
                default: reg_index = `PMAC_IDX_NONE;
            endcase
        end
    endfunction

    // the operation implied by a first-operand address
    function [1:0] addr_mode;
        input [15:0] addr;
        begin
            case (addr)
                `PMAC_ADDR_OPA_SPROD: addr_mode = `PMAC_MODE_SPROD;
                `PMAC_ADDR_OPA_UACC: addr_mode = `PMAC_MODE_UACC;
                `PMAC_ADDR_OPA_SACC: addr_mode = `PMAC_MODE_SACC;
                default: addr_mode = `PMAC_MODE_UPROD;
            endcase
        end
    endfunction

    // true for either signed mode
    function is_signed_mode;
        input [1:0] mode;
        begin
            is_signed_mode = (mode == `PMAC_MODE_SPROD) || (mode == `PMAC_MODE_SACC);
        end
    endfunction

    // zero-extends the low byte of a bus word, as every byte write does
    // RULE_17: upper byte cleared
    function [WIDTH-1:0] byte_word;
        input [WIDTH-1:0] data;
        begin
            byte_word = {{(WIDTH-8){1'b0}}, data[`PMAC_BYTE_MSB:`PMAC_BYTE_LSB]};
        end
    endfunction

    // byte writes land only on the even (low) byte address
    wire wr_ok;
    wire [3:0] wr_idx;
    wire [3:0] rd_idx;
    wire wr_opa;
    wire wr_opb;
    wire wr_res_lo;
    wire wr_res_hi;

    wire [WIDTH-1:0] op_a;
    wire [WIDTH-1:0] op_b;
    wire mul_valid;
    wire [2*WIDTH-1:0] product;

    // control flags and the read data word are reset; operand, sum and result words are not, so reset fans out to few flops
    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg start_reg;
    reg [1:0] start_mode_reg;
    reg [1:0] mul_mode_reg;
    reg sum_valid_reg;
    reg [2*WIDTH-1:0] sum_reg;
    reg [2*WIDTH-1:0] sum_next;
    reg [WIDTH-1:0] ext_reg;
    reg [WIDTH-1:0] ext_next;
    reg [WIDTH-1:0] res_lo_reg;
    reg [WIDTH-1:0] res_lo_next;
    reg [WIDTH-1:0] res_hi_reg;
    reg [WIDTH-1:0] res_hi_next;
    reg [WIDTH-1:0] res_ext_reg;
    reg [WIDTH-1:0] res_ext_next;
    reg [WIDTH-1:0] rdata_reg;
    reg [WIDTH-1:0] rdata_next;
    reg [WIDTH-1:0] wr_value;
    reg [2*WIDTH-1:0] acc_value;
    wire [2*WIDTH:0] usum;
    wire [2*WIDTH:0] ssum;

    // odd-address byte writes have no documented meaning and are dropped
    assign wr_ok = per_wen && !(per_byte && per_addr[0]);
    assign wr_idx = wr_ok ? reg_index(per_addr) : `PMAC_IDX_NONE;
    assign rd_idx = reg_index(per_addr);

    // RULE_02: store and latch only
    assign wr_opa = (wr_idx == `PMAC_IDX_OPA);
    // RULE_03: operand b write starts
    assign wr_opb = (wr_idx == `PMAC_IDX_OPB);
    assign wr_res_lo = (wr_idx == `PMAC_IDX_RES_LO);
    assign wr_res_hi = (wr_idx == `PMAC_IDX_RES_HI);

    // byte writes to result words follow the same zero-extension as operands
    always @* begin
        if (per_byte) begin
            wr_value = byte_word(per_wdata);
        end else begin
            wr_value = per_wdata;
        end
    end

    // operands have no reset, so they keep their values across a system reset
    // first operand, shared by all four mode addresses
    // RULE_05: kept between operations
    pmac_operand_reg #(
        .WIDTH(WIDTH)
    ) u_opa (
        .clk(clk),
        .wen(wr_opa),
        .byte_wr(per_byte),
        .wdata(per_wdata),
        .q(op_a)
    );

    // second operand; its write is also the start strobe
    pmac_operand_reg #(
        .WIDTH(WIDTH)
    ) u_opb (
        .clk(clk),
        .wen(wr_opb),
        .byte_wr(per_byte),
        .wdata(per_wdata),
        .q(op_b)
    );

    // mode selection follows the address of the last first-operand write
    always @* begin
        mode_next = mode_reg;
        // RULE_01: address picks the mode
        if (wr_opa) begin
            mode_next = addr_mode(per_addr);
        end
    end

    // an interrupt handler that rewrites the first operand replaces this mode
    always @(posedge clk) begin
        if (srst) begin
            mode_reg <= `PMAC_MODE_RESET;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // pipe timing, counted from the edge e0 that takes the second operand:
    // e0 start_reg set, e1 product registered, e2 sum and extension registered,
    // e3 result registers loaded, so a read taken at e0+4 sees the new results
    // stage 0: the start strobe waits one edge so the operands are settled
    // RULE_03: launch the latched mode
    always @(posedge clk) begin
        if (srst) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= wr_opb;
        end
    end

    // the mode travels with its operands through the pipe
    // a first-operand write during a run changes only later operations
    always @(posedge clk) begin
        start_mode_reg <= mode_reg;
        mul_mode_reg <= start_mode_reg;
    end

    // stage 1: registered product
    // the signed flag comes from the mode captured with the start strobe
    pmac_multiplier #(
        .WIDTH(WIDTH)
    ) u_mul (
        .clk(clk),
        .srst(srst),
        .in_valid(start_reg),
        .is_signed(is_signed_mode(start_mode_reg)),
        .op_a(op_a),
        .op_b(op_b),
        .out_valid(mul_valid),
        .product(product)
    );

    // the accumulator takes a write-back or a CPU write landing in this same cycle,
    // so starts only one or two edges apart still chain their sums
    // RULE_16: newest accumulator value
    always @* begin
        acc_value = {res_hi_next, res_lo_next};
    end

    // both 33-bit sums are formed at once; the mode picks one below
    // RULE_10: carry lands in bit 32
    assign usum = {1'b0, product} + {1'b0, acc_value};
    // RULE_11: sign-extended, wraps in 32 bits
    assign ssum = {product[2*WIDTH-1], product} + {acc_value[2*WIDTH-1], acc_value};

    // stage 2: mode-specific result word and extension word
    // the extension follows the mode that travelled with this product
    always @* begin
        sum_next = product;
        ext_next = `PMAC_EXT_ZERO;
        case (mul_mode_reg)
            `PMAC_MODE_UPROD: begin
                // RULE_07: extension forced zero
                sum_next = product;
                ext_next = `PMAC_EXT_ZERO;
            end
            `PMAC_MODE_SPROD: begin
                // RULE_09: sign fills extension
                sum_next = product;
                ext_next = product[2*WIDTH-1] ? `PMAC_EXT_ONES : `PMAC_EXT_ZERO;
            end
            `PMAC_MODE_UACC: begin
                // RULE_16: add to result pair
                sum_next = usum[2*WIDTH-1:0];
                // RULE_10: carry into extension
                ext_next = usum[2*WIDTH] ? `PMAC_EXT_CARRY : `PMAC_EXT_ZERO;
            end
            `PMAC_MODE_SACC: begin
                // RULE_11: 32-bit wrapping sum
                sum_next = ssum[2*WIDTH-1:0];
                // RULE_12: true sign, no flag
                ext_next = ssum[2*WIDTH] ? `PMAC_EXT_ONES : `PMAC_EXT_ZERO;
            end
            default: begin
                sum_next = product;
                ext_next = `PMAC_EXT_ZERO;
            end
        endcase
    end

    // the write-back flag trails the product flag by one edge
    always @(posedge clk) begin
        if (srst) begin
            sum_valid_reg <= 1'b0;
        end else begin
            sum_valid_reg <= mul_valid;
        end
    end

    // sum and extension words carry no reset value
    // only the valid flag decides whether they are ever used
    always @(posedge clk) begin
        sum_reg <= sum_next;
        ext_reg <= ext_next;
    end

    // stage 3: result registers; the pipeline wins over a CPU write in the same cycle
    // a CPU write to the result pair is how software seeds the accumulator
    always @* begin
        res_lo_next = res_lo_reg;
        res_hi_next = res_hi_reg;
        res_ext_next = res_ext_reg;
        if (wr_res_lo) begin
            res_lo_next = wr_value;
        end
        if (wr_res_hi) begin
            res_hi_next = wr_value;
        end
        // RULE_04: all three together
        if (sum_valid_reg) begin
            // RULE_06: low word from bits 15..0
            res_lo_next = sum_reg[WIDTH-1:0];
            // RULE_07: upper half into high word
            res_hi_next = sum_reg[2*WIDTH-1:WIDTH];
            res_ext_next = ext_reg;
        end
    end

    // results are undefined after reset, so they are not reset
    always @(posedge clk) begin
        res_lo_reg <= res_lo_next;
        res_hi_reg <= res_hi_next;
        res_ext_reg <= res_ext_next;
    end

    // read data mux; unmapped addresses answer zero
    // the first operand reads back alike at all four mode addresses
    always @* begin
        case (rd_idx)
            `PMAC_IDX_OPA: rdata_next = op_a;
            `PMAC_IDX_OPB: rdata_next = op_b;
            `PMAC_IDX_RES_LO: rdata_next = res_lo_reg;
            `PMAC_IDX_RES_HI: rdata_next = res_hi_reg;
            `PMAC_IDX_RES_EXT: rdata_next = res_ext_reg;
            default: rdata_next = `PMAC_RDATA_UNMAPPED;
        endcase
    end

    // read data is registered and holds until the next read
    // RULE_14: direct read lands after results
    always @(posedge clk) begin
        if (srst) begin
            rdata_reg <= `PMAC_RDATA_RESET;
        end else if (per_ren) begin
            rdata_reg <= rdata_next;
        end
    end

    // busy covers the whole pipe, result_valid marks the write-back edge
    // the CPU itself relies on the fixed latency; these two are for observation
    assign busy = start_reg | mul_valid | sum_valid_reg;
    assign result_valid = sum_valid_reg;
    assign per_rdata = rdata_reg;

endmodule // pmac_top

//--- test/pmac_cpu_model.sv
`timescale 1ns/100ps

// cpu side of the peripheral bus; drives only at falling edges
module pmac_cpu_model (
    input wire clk,
    output logic [15:0] per_addr = 16'h0000,
    output logic [15:0] per_wdata = 16'h0000,
    output logic per_wen = 1'b0,
    output logic per_byte = 1'b0,
    output logic per_ren = 1'b0,
    input wire [15:0] per_rdata
);
    // released lines are scrambled so a stale value never looks valid
    task automatic idle();
        per_wen = 1'b0;
        per_ren = 1'b0;
        per_addr = ~per_addr;
        per_wdata = ~per_wdata;
    endtask
    // one write, held across exactly one taking edge
    task automatic wr(input [15:0] a, input [15:0] d, input b);
        @(negedge clk);
        per_addr = a;
        per_wdata = d;
        per_byte = b;
        per_wen = 1'b1;
        @(negedge clk);
        idle();
    endtask
    // read spacing: callers leave three idle cycles after a start before reading results
    task automatic rd(input [15:0] a, output [15:0] d);
        @(negedge clk);
        per_addr = a;
        per_ren = 1'b1;
        @(negedge clk);
        d = per_rdata;
        idle();
    endtask
endmodule // pmac_cpu_model

//--- test/pmac_top_assertions.sv
`timescale 1ns/100ps
`include "pmac_regs.vh"

// watches bus accesses and pipeline flags at the top ports
module pmac_checker #(
    parameter WIDTH = 16
) (
    input wire clk,
    input wire srst,
    input wire [15:0] per_addr,
    input wire [WIDTH-1:0] per_wdata,
    input wire per_wen,
    input wire per_byte,
    input wire per_ren,
    input wire [WIDTH-1:0] per_rdata,
    input wire busy,
    input wire result_valid
);
    // odd-address byte writes are refused, so they must start nothing
    wire ok_wr = per_wen && !(per_byte && per_addr[0]);
    wire opb_wr = ok_wr && per_addr == `PMAC_ADDR_OPB;
    wire opa_wr = ok_wr && per_addr[15:3] == 13'h0026;
    wire opa_rd = per_ren && per_addr[15:3] == 13'h0026;
    wire ext_rd = per_ren && per_addr == `PMAC_ADDR_RES_EXT;
    wire ext_wr = per_wen && per_addr == `PMAC_ADDR_RES_EXT;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    opb_start_a: assert property (opb_wr |=> busy)
        else $error("busy did not follow a start write");
    start_cause_a: assert property (result_valid |-> $past(opb_wr, 3))
        else $error("result pulse without a start three cycles back");
    result_time_a: assert property (opb_wr |-> ##3 result_valid)
        else $error("result pulse missing three cycles after start");
    pipe_drain_a: assert property (opb_wr ##1 (!opb_wr) [*3] |=> !busy)
        else $error("busy still high after results loaded");
    opa_quiet_a: assert property (opa_wr && !busy |=> !busy)
        else $error("first operand write started an operation");
    opa_keep_a: assert property (opa_wr && !per_byte ##2 opa_rd |=>
        per_rdata == $past(per_wdata, 3)) else $error("first operand not held");
    byte_clear_a: assert property (opb_wr && per_byte ##2
        (per_ren && per_addr == `PMAC_ADDR_OPB) |=> per_rdata[15:8] == 8'h00)
        else $error("byte write left upper byte set");
    byte_low_a: assert property (opb_wr && per_byte ##2
        (per_ren && per_addr == `PMAC_ADDR_OPB) |=> per_rdata[7:0] == $past(per_wdata[7:0], 3))
        else $error("byte write lost low byte");
    ext_ro_a: assert property (ext_rd ##2 (ext_wr && !busy) ##2 ext_rd |=>
        $stable(per_rdata)) else $error("extension register took a write");
    start_c: cover property (opb_wr);
    pulse_c: cover property (result_valid);
    byte_c: cover property (opb_wr && per_byte);
    chain_c: cover property (opb_wr ##2 opb_wr);
endmodule // pmac_checker

bind pmac_top pmac_checker #(.WIDTH(WIDTH)) pmac_checker_inst (.clk(clk), .srst(srst),
    .per_addr(per_addr), .per_wdata(per_wdata), .per_wen(per_wen), .per_byte(per_byte),
    .per_ren(per_ren), .per_rdata(per_rdata), .busy(busy), .result_valid(result_valid));

//--- test/pmac_top_bench.sv
`timescale 1ns/100ps
`include "pmac_regs.vh"

module pmac_top_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    wire [15:0] per_addr;
    wire [15:0] per_wdata;
    wire per_wen;
    wire per_byte;
    wire per_ren;
    wire [15:0] per_rdata;
    integer failures = 0;
    integer compares = 0;
    integer i;
    integer j;
    logic [31:0] seed = 32'h89fa;
    logic [31:0] r;
    logic [31:0] acc;
    logic [15:0] opa_val;
    logic [15:0] rv;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] ext;
    logic [47:0] chain;

    initial begin
        forever #4 clk = ~clk;
    end

    pmac_top #(.WIDTH(16)) pmac_top_inst (.clk(clk), .srst(srst), .per_addr(per_addr),
        .per_wdata(per_wdata), .per_wen(per_wen), .per_byte(per_byte), .per_ren(per_ren),
        .per_rdata(per_rdata), .busy(), .result_valid());
    pmac_cpu_model cpu_inst (.clk(clk), .per_addr(per_addr), .per_wdata(per_wdata),
        .per_wen(per_wen), .per_byte(per_byte), .per_ren(per_ren), .per_rdata(per_rdata));

    function automatic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected {extension, high, low}; if/else keeps signed products signed
    function automatic [47:0] calc(input [1:0] m, input [15:0] a, input [15:0] b,
        input [31:0] acc_in);
        logic [31:0] p;
        logic [32:0] s;
        if (m[0]) p = $signed(a) * $signed(b);
        else p = a * b;
        s = {m[0] & p[31], p};
        if (m[1]) s = s + {m[0] & acc_in[31], acc_in};
        if (m == `PMAC_MODE_UACC) return {15'h0000, s[32], s[31:0]};
        if (m == `PMAC_MODE_UPROD) return {16'h0000, s[31:0]};
        return {{16{s[32]}}, s[31:0]};
    endfunction

    task check(input [47:0] seen, input [47:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task report_and_stop();
        $display("counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // seeds the accumulator through the writable result pair
    task set_acc(input [31:0] v);
        cpu_inst.wr(`PMAC_ADDR_RES_LO, v[15:0], 1'b0);
        cpu_inst.wr(`PMAC_ADDR_RES_HI, v[31:16], 1'b0);
        acc = v;
    endtask

    // first operand write at the mode address, then read back
    task opa(input [1:0] m, input [15:0] a, input ab);
        opa_val = ab ? {8'h00, a[7:0]} : a;
        cpu_inst.wr(`PMAC_ADDR_OPA_UPROD + {m, 1'b0}, a, ab);
        cpu_inst.rd(`PMAC_ADDR_OPA_UPROD + {m, 1'b0}, rv);
        check({32'h0, rv}, {32'h0, opa_val});
    endtask

    // start with a second operand and read all three results as early as allowed
    task run(input [1:0] m, input [15:0] b, input bb);
        logic [47:0] exp;
        exp = calc(m, opa_val, bb ? {8'h00, b[7:0]} : b, acc);
        // operand pair: no other operation between them
        cpu_inst.wr(`PMAC_ADDR_OPB, b, bb);
        repeat (2) @(negedge clk);
        cpu_inst.rd(`PMAC_ADDR_RES_LO, lo);
        cpu_inst.rd(`PMAC_ADDR_RES_HI, hi);
        cpu_inst.rd(`PMAC_ADDR_RES_EXT, ext);
        check({ext, hi, lo}, exp);
        acc = exp[31:0];
    endtask

    initial begin
        repeat (3) @(negedge clk);
        srst = 1'b0;
        set_acc(xs());
        cpu_inst.rd(`PMAC_ADDR_RES_LO, lo);
        cpu_inst.rd(`PMAC_ADDR_RES_HI, hi);
        check({16'h0, hi, lo}, {16'h0, acc});
        cpu_inst.rd(16'h0140, rv);
        check({32'h0, rv}, {32'h0, `PMAC_RDATA_UNMAPPED});
        $display("register access test done");
        // carry out, then signed underflow and overflow
        set_acc(32'hffff_ffff);
        opa(`PMAC_MODE_UACC, 16'hffff, 1'b0);
        run(`PMAC_MODE_UACC, 16'hffff, 1'b0);
        set_acc(32'h8000_0000);
        opa(`PMAC_MODE_SACC, 16'h8000, 1'b0);
        run(`PMAC_MODE_SACC, 16'h0001, 1'b0);
        set_acc(32'h7fff_ffff);
        opa(`PMAC_MODE_SACC, 16'h0001, 1'b0);
        run(`PMAC_MODE_SACC, 16'h0001, 1'b0);
        // extension ignores a write
        cpu_inst.rd(`PMAC_ADDR_RES_EXT, lo);
        cpu_inst.wr(`PMAC_ADDR_RES_EXT, ~lo, 1'b0);
        cpu_inst.rd(`PMAC_ADDR_RES_EXT, hi);
        check({32'h0, hi}, {32'h0, lo});
        // two starts two edges apart: the second adds to the first sum
        opa(`PMAC_MODE_UACC, 16'hfedc, 1'b0);
        chain = calc(`PMAC_MODE_UACC, opa_val, 16'h1357, acc);
        cpu_inst.wr(`PMAC_ADDR_OPB, 16'h1357, 1'b0);
        acc = chain[31:0];
        run(`PMAC_MODE_UACC, 16'h2468, 1'b0);
        // byte second operand read back mid-operation
        opa(`PMAC_MODE_UPROD, 16'h1234, 1'b0);
        cpu_inst.wr(`PMAC_ADDR_OPB, 16'hab5c, 1'b1);
        cpu_inst.rd(`PMAC_ADDR_OPB, rv);
        check({32'h0, rv}, {32'h0, 16'h005c});
        repeat (3) @(negedge clk);
        $display("corner case test done");
        // reset after a first-operand write, before the start: operands survive, mode falls back to unsigned product
        opa(`PMAC_MODE_SACC, 16'h8001, 1'b0);
        @(negedge clk);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        run(`PMAC_MODE_UPROD, 16'h8003, 1'b0);
        $display("reset test done");
        // every mode twice, operand kept for three starts each
        set_acc(xs());
        for (i = 0; i < 8; i = i + 1) begin
            r = xs();
            opa(i[1:0], r[15:0], r[16]);
            for (j = 0; j < 3; j = j + 1) begin
                r = xs();
                run(i[1:0], r[15:0], r[16]);
            end
        end
        $display("random mode test done");
        report_and_stop();
    end

    // runs far longer than the tests need
    initial begin
        #200000;
        failures = failures + 1;
        report_and_stop();
    end
endmodule // pmac_top_bench
